// ### hw/lsc_cmd_regs.v
// Behaviour
// - Plain writes carry no count; data bytes are taken until the stop.
// - Combined word and block reads return successive bytes until the host stops the transfer; byte reads repeat one register.
// - Sixteen registers plus a command pointer, reached only over the serial link.
// - Timing 01h, interrupt 02h, gain 07h read/write; control 00h too, except bits 5 and 4 read back status.
// - Low threshold at 03h/04h, high threshold at 05h/06h, read/write.
// - Read-only part and revision code at 12h.
// - Address 13h reads the block_count_four 4 for block reads.
// - Channel 0 result at 14h/15h, channel 1 at 16h/17h, read-only.
// - Manual integration length at 18h low, 19h high, read-only.
// - Eight-bit pointer selects the target until it is rewritten.
// - Pointer clears to zero at power-up.
// - Results are readable and control registers writable.
// - A byte with top bit set loads the pointer; others are data.
// - Every receive-byte answer is the register the stored pointer selects.
// - Block read at 13h (code D3h) leads with count 4, then results.
`timescale 1ns/10ps

`include "lsc_defines.vh"

// ----------------------------------------------------------------------
// Command interpreter and register file of the light sensor
// ----------------------------------------------------------------------
module lsc_cmd_regs #(
   // Set to 1 for the SMBus flavour: the count byte after a block command is dropped.
   parameter SMBUS_MODE = 0
) (
   // Clock and reset.
   input wire clk,
   input wire rstn,
   // Two-wire serial pins; the data line is open drain.
   input wire sclIn,
   input wire sdaIn,
   output wire sdaOut,
   output wire sdaOe,
   // Conversion side state, on the same clock.
   input wire [15:0] ch0Result,
   input wire [15:0] ch1Result,
   input wire [15:0] manualPeriod,
   input wire adcIrqActive,
   input wire adcValid,
   // Configuration towards the conversion side.
   output wire [7:0] powerAdcCtrl,
   output wire [7:0] integrationTime,
   output wire [7:0] irqCtrl,
   output wire [15:0] lowThresh,
   output wire [15:0] highThresh,
   output wire [7:0] gainCtrl,
   // Special function strobes, one cycle each.
   output reg irqClearPulse_ff,
   output reg manualStopPulse_ff,
   output reg manualStartPulse_ff
);

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   wire [1:0] pinSync;
   wire startPulse;
   wire stopPulse;
   wire rxValid;
   wire [7:0] rxByte;
   wire txLoad;
   wire [7:0] txData;
   wire [1:0] transType;
   wire [4:0] curAddr;
   wire isCommand;
   reg [7:0] cfgMem_ff [0:`LSC_CFG_REGS-1];
   reg [7:0] pointer_ff;
   reg [4:0] offset_ff;
   reg skipCount_ff;
   reg [4:0] nxt_offset;
   integer ri;

   // ----------------------------------------------------------------------
   // Pin synchronisers and byte-level slave
   // ----------------------------------------------------------------------
   // The serial clock is sampled, not used as a clock, so both pins are synchronised.
   lsc_sync2 #(
      .WIDTH(2)
   ) uSync (
      .clk(clk),
      .rstn(rstn),
      .asyncIn({sclIn, sdaIn}),
      .syncOut(pinSync)
   );

   // Registers are reachable only through this slave.
   lsc_link_slave uSlave (
      .clk(clk),
      .rstn(rstn),
      .sclSync(pinSync[1]),
      .sdaSync(pinSync[0]),
      .sdaOut(sdaOut),
      .sdaOe_ff(sdaOe),
      .startPulse_ff(startPulse),
      .stopPulse_ff(stopPulse),
      .rxValid_ff(rxValid),
      .rxByte_ff(rxByte),
      .txData(txData),
      .txLoad_ff(txLoad)
   );

   // ----------------------------------------------------------------------
   // Pointer decode
   // ----------------------------------------------------------------------
   // Transaction type and base address come from the stored pointer.
   assign transType = pointer_ff[`LSC_TRANS_HI:`LSC_TRANS_LO];
   assign curAddr = pointer_ff[`LSC_ADDR_HI:0] + offset_ff;
   assign isCommand = rxByte[`LSC_CMD_BIT];

   // ----------------------------------------------------------------------
   // Read multiplexer
   // ----------------------------------------------------------------------
   // The pointer itself never appears here, so it cannot be read back.
   function [7:0] regRead;
      input [4:0] addr;
      begin
         regRead = 8'h00;
         if (addr == `LSC_ADDR_CTRL)
         begin
            regRead = cfgMem_ff[0];
            regRead[`LSC_CTRL_IRQ_BIT] = adcIrqActive;
            regRead[`LSC_CTRL_VALID_BIT] = adcValid;
         end
         else if (addr <= `LSC_ADDR_GAIN)
         begin
            regRead = cfgMem_ff[addr[2:0]];
         end
         else if (addr == `LSC_ADDR_PART_REV)
         begin
            regRead = `LSC_PART_REV_VAL;
         end
         else if (addr == `LSC_ADDR_BLK_COUNT)
         begin
            regRead = `LSC_BLK_COUNT_VAL;
         end
         else if (addr == `LSC_ADDR_CH0_LSB)
         begin
            regRead = ch0Result[7:0];
         end
         else if (addr == `LSC_ADDR_CH0_MSB)
         begin
            regRead = ch0Result[15:8];
         end
         else if (addr == `LSC_ADDR_CH1_LSB)
         begin
            regRead = ch1Result[7:0];
         end
         else if (addr == `LSC_ADDR_CH1_MSB)
         begin
            regRead = ch1Result[15:8];
         end
         else if (addr == `LSC_ADDR_MAN_LSB)
         begin
            regRead = manualPeriod[7:0];
         end
         else if (addr == `LSC_ADDR_MAN_MSB)
         begin
            regRead = manualPeriod[15:8];
         end
      end
   endfunction

   // Each byte sent answers with the currently selected register.
   assign txData = regRead(curAddr);

   // ----------------------------------------------------------------------
   // Auto-increment offset
   // ----------------------------------------------------------------------
   // Word and block transfers walk upward from the pointer; byte transfers stay put.
   // A block read from 13h therefore yields the count 4 and then all four
   // result bytes with no extra logic.
   always @*
   begin
      nxt_offset = offset_ff;
      if (startPulse)
      begin
         nxt_offset = 5'h00;
      end
      else if (rxValid && isCommand)
      begin
         nxt_offset = 5'h00;
      end
      else if ((txLoad || (rxValid && !skipCount_ff)) && transType != `LSC_TRANS_BYTE)
      begin
         nxt_offset = offset_ff + 5'h01;
      end
   end

   // ----------------------------------------------------------------------
   // Command, data and special function handling
   // ----------------------------------------------------------------------
   // The pointer holds its value between transactions, so a host can write it
   // once and then issue any number of plain reads.
   always @(posedge clk)
   begin
      if (!rstn)
      begin
         pointer_ff <= `LSC_PTR_RESET;
         offset_ff <= 5'h00;
         skipCount_ff <= 1'b0;
         irqClearPulse_ff <= 1'b0;
         manualStopPulse_ff <= 1'b0;
         manualStartPulse_ff <= 1'b0;
         for (ri = 0; ri < `LSC_CFG_REGS; ri = ri + 1)
         begin
            cfgMem_ff[ri] <= `LSC_CFG_RESET;
         end
      end
      else
      begin
         offset_ff <= nxt_offset;
         irqClearPulse_ff <= 1'b0;
         manualStopPulse_ff <= 1'b0;
         manualStartPulse_ff <= 1'b0;
         if (stopPulse)
         begin
            skipCount_ff <= 1'b0;
         end
         if (rxValid)
         begin
            if (isCommand)
            begin
               // Any byte with the top bit set reloads the pointer.
               pointer_ff <= rxByte;
               skipCount_ff <= (SMBUS_MODE != 0) &&
                  (rxByte[`LSC_TRANS_HI:`LSC_TRANS_LO] == `LSC_TRANS_BLOCK);
               if (rxByte[`LSC_TRANS_HI:`LSC_TRANS_LO] == `LSC_TRANS_SPECIAL)
               begin
                  // The clear fires on the command byte alone, as a send byte.
                  if (rxByte[`LSC_ADDR_HI:0] == `LSC_SF_IRQ_CLEAR)
                  begin
                     irqClearPulse_ff <= 1'b1;
                  end
                  // Manual integration only applies while timing is zero.
                  if (cfgMem_ff[1] == `LSC_TIMING_MANUAL)
                  begin
                     manualStopPulse_ff <= (rxByte[`LSC_ADDR_HI:0] == `LSC_SF_MAN_STOP);
                     manualStartPulse_ff <= (rxByte[`LSC_ADDR_HI:0] == `LSC_SF_MAN_START);
                  end
               end
            end
            else if (skipCount_ff)
            begin
               // The SMBus count byte is dropped; the real length is the stop.
               skipCount_ff <= 1'b0;
            end
            else if (transType != `LSC_TRANS_SPECIAL && curAddr <= `LSC_ADDR_GAIN)
            begin
               // Only 00h to 07h are writable; read-only targets drop the byte.
               cfgMem_ff[curAddr[2:0]] <= rxByte;
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Configuration outputs
   // ----------------------------------------------------------------------
   // Thresholds pair low byte at the lower address with high byte above it.
   assign powerAdcCtrl = cfgMem_ff[0];
   assign integrationTime = cfgMem_ff[1];
   assign irqCtrl = cfgMem_ff[2];
   assign lowThresh = {cfgMem_ff[4], cfgMem_ff[3]};
   assign highThresh = {cfgMem_ff[6], cfgMem_ff[5]};
   assign gainCtrl = cfgMem_ff[7];

endmodule

// ### hw/lsc_defines.vh
`ifndef LSC_DEFINES_VH
`define LSC_DEFINES_VH

// ----------------------------------------------------------------------
// Serial link constants
// ----------------------------------------------------------------------
// Seven-bit slave address answered on the two-wire link.
`define LSC_SLAVE_ADDR 7'h39
// Bits in one serial byte.
`define LSC_BYTE_BITS 4'h8

// ----------------------------------------------------------------------
// Command byte layout
// ----------------------------------------------------------------------
`define LSC_CMD_BIT 7
`define LSC_TRANS_HI 6
`define LSC_TRANS_LO 5
`define LSC_ADDR_HI 4
`define LSC_PTR_RESET 8'h00
`define LSC_TRANS_BYTE 2'h0
`define LSC_TRANS_WORD 2'h1
`define LSC_TRANS_BLOCK 2'h2
`define LSC_TRANS_SPECIAL 2'h3
`define LSC_SF_IRQ_CLEAR 5'h01
`define LSC_SF_MAN_STOP 5'h02
`define LSC_SF_MAN_START 5'h03

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define LSC_ADDR_CTRL 5'h00
`define LSC_ADDR_TIMING 5'h01
`define LSC_ADDR_IRQ 5'h02
`define LSC_ADDR_LOW_LSB 5'h03
`define LSC_ADDR_LOW_MSB 5'h04
`define LSC_ADDR_HIGH_LSB 5'h05
`define LSC_ADDR_HIGH_MSB 5'h06
`define LSC_ADDR_GAIN 5'h07
`define LSC_ADDR_PART_REV 5'h12
`define LSC_ADDR_BLK_COUNT 5'h13
`define LSC_ADDR_CH0_LSB 5'h14
`define LSC_ADDR_CH0_MSB 5'h15
`define LSC_ADDR_CH1_LSB 5'h16
`define LSC_ADDR_CH1_MSB 5'h17
`define LSC_ADDR_MAN_LSB 5'h18
`define LSC_ADDR_MAN_MSB 5'h19

// ----------------------------------------------------------------------
// Register contents
// ----------------------------------------------------------------------
// Part and revision code; the value is arbitrary.
`define LSC_PART_REV_VAL 8'h5A
`define LSC_BLK_COUNT_VAL 8'h04
`define LSC_CFG_RESET 8'h00
`define LSC_TIMING_MANUAL 8'h00
`define LSC_CTRL_IRQ_BIT 5
`define LSC_CTRL_VALID_BIT 4
`define LSC_CFG_REGS 8

`endif

// ### hw/lsc_link_slave.v
`timescale 1ns/10ps

`include "lsc_defines.vh"

// ----------------------------------------------------------------------
// Byte-level two-wire slave: framing, address match, acknowledge
// ----------------------------------------------------------------------
module lsc_link_slave (
   // Clock and reset.
   input wire clk,
   input wire rstn,
   // Synchronised bus levels and data line drive.
   input wire sclSync,
   input wire sdaSync,
   output wire sdaOut,
   output reg sdaOe_ff,
   // Frame events towards the command logic.
   output reg startPulse_ff,
   output reg stopPulse_ff,
   output reg rxValid_ff,
   output reg [7:0] rxByte_ff,
   // Transmit byte source; txLoad marks the cycle it is taken.
   input wire [7:0] txData,
   output reg txLoad_ff
);

   localparam ST_IDLE = 3'd0;
   localparam ST_ADDR = 3'd1;
   localparam ST_ACK_ADDR = 3'd2;
   localparam ST_WRITE = 3'd3;
   localparam ST_ACK_RX = 3'd4;
   localparam ST_READ = 3'd5;
   localparam ST_ACK_TX = 3'd6;

   reg [2:0] state_ff;
   reg [3:0] bitCnt_ff;
   reg [7:0] shift_ff;
   reg readDir_ff;
   reg sclPrev_ff;
   reg sdaPrev_ff;
   wire sclRise;
   wire sclFall;
   wire startSeen;
   wire stopSeen;

   // The line is only ever pulled low; the enable carries the data.
   assign sdaOut = 1'b0;
   assign sclRise = sclSync & ~sclPrev_ff;
   assign sclFall = ~sclSync & sclPrev_ff;
   assign startSeen = sclSync & sclPrev_ff & sdaPrev_ff & ~sdaSync;
   assign stopSeen = sclSync & sclPrev_ff & ~sdaPrev_ff & sdaSync;

   // Both lines pass the same delay, so their relative order is kept.
   always @(posedge clk)
   begin
      if (!rstn)
      begin
         state_ff <= ST_IDLE;
         bitCnt_ff <= 4'h0;
         shift_ff <= 8'h00;
         readDir_ff <= 1'b0;
         sclPrev_ff <= 1'b1;
         sdaPrev_ff <= 1'b1;
         sdaOe_ff <= 1'b0;
         startPulse_ff <= 1'b0;
         stopPulse_ff <= 1'b0;
         rxValid_ff <= 1'b0;
         rxByte_ff <= 8'h00;
         txLoad_ff <= 1'b0;
      end
      else
      begin
         sclPrev_ff <= sclSync;
         sdaPrev_ff <= sdaSync;
         startPulse_ff <= startSeen;
         stopPulse_ff <= stopSeen;
         rxValid_ff <= 1'b0;
         txLoad_ff <= 1'b0;
         if (startSeen)
         begin
            state_ff <= ST_ADDR;
            bitCnt_ff <= 4'h0;
            sdaOe_ff <= 1'b0;
         end
         else if (stopSeen)
         begin
            state_ff <= ST_IDLE;
            sdaOe_ff <= 1'b0;
         end
         else
         begin
            case (state_ff)
               ST_ADDR, ST_WRITE:
               begin
                  if (sclRise)
                  begin
                     shift_ff <= {shift_ff[6:0], sdaSync};
                     bitCnt_ff <= bitCnt_ff + 4'h1;
                  end
                  else if (sclFall && bitCnt_ff == `LSC_BYTE_BITS)
                  begin
                     bitCnt_ff <= 4'h0;
                     if (state_ff == ST_WRITE)
                     begin
                        rxValid_ff <= 1'b1;
                        rxByte_ff <= shift_ff;
                        sdaOe_ff <= 1'b1;
                        state_ff <= ST_ACK_RX;
                     end
                     else if (shift_ff[7:1] == `LSC_SLAVE_ADDR)
                     begin
                        readDir_ff <= shift_ff[0];
                        sdaOe_ff <= 1'b1;
                        state_ff <= ST_ACK_ADDR;
                     end
                     else
                     begin
                        state_ff <= ST_IDLE;
                     end
                  end
               end
               ST_ACK_ADDR, ST_ACK_RX:
               begin
                  // Master writes keep flowing until a stop; no count is kept.
                  if (sclFall)
                  begin
                     if (readDir_ff)
                     begin
                        shift_ff <= txData;
                        sdaOe_ff <= ~txData[7];
                        txLoad_ff <= 1'b1;
                        bitCnt_ff <= 4'h1;
                        state_ff <= ST_READ;
                     end
                     else
                     begin
                        sdaOe_ff <= 1'b0;
                        state_ff <= ST_WRITE;
                     end
                  end
               end
               ST_READ:
               begin
                  if (sclFall)
                  begin
                     if (bitCnt_ff == `LSC_BYTE_BITS)
                     begin
                        sdaOe_ff <= 1'b0;
                        state_ff <= ST_ACK_TX;
                     end
                     else
                     begin
                        sdaOe_ff <= ~shift_ff[6];
                        shift_ff <= {shift_ff[6:0], 1'b0};
                        bitCnt_ff <= bitCnt_ff + 4'h1;
                     end
                  end
               end
               ST_ACK_TX:
               begin
                  // A not-acknowledge ends sending; otherwise the next byte goes out.
                  if (sclRise && sdaSync)
                  begin
                     state_ff <= ST_IDLE;
                  end
                  else if (sclFall)
                  begin
                     shift_ff <= txData;
                     sdaOe_ff <= ~txData[7];
                     txLoad_ff <= 1'b1;
                     bitCnt_ff <= 4'h1;
                     state_ff <= ST_READ;
                  end
               end
               default:
               begin
                  sdaOe_ff <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule

// ### hw/lsc_sync2.v
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Two-stage synchroniser, one chain per bit
// ----------------------------------------------------------------------
module lsc_sync2 #(
   parameter WIDTH = 2
) (
   // Clock and reset.
   input wire clk,
   input wire rstn,
   // Asynchronous levels in, synchronised levels out.
   input wire [WIDTH-1:0] asyncIn,
   output wire [WIDTH-1:0] syncOut
);

   genvar gi;

   // Reset to ones because an idle two-wire bus floats high.
   generate
      for (gi = 0; gi < WIDTH; gi = gi + 1)
      begin : gSync
         reg stage1_ff;
         reg stage2_ff;
         always @(posedge clk)
         begin
            if (!rstn)
            begin
               stage1_ff <= 1'b1;
               stage2_ff <= 1'b1;
            end
            else
            begin
               stage1_ff <= asyncIn[gi];
               stage2_ff <= stage1_ff;
            end
         end
         assign syncOut[gi] = stage2_ff;
      end
   endgenerate

endmodule

// ### tb/lsc_cmd_regs_props.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Port checker for the command interpreter
// ----------------------------------------------------------------------
module lsc_cmd_regs_props (
   // Clock and reset.
   input wire clk,
   input wire rstn,
   // Serial pins.
   input wire sclIn,
   input wire sdaIn,
   input wire sdaOut,
   input wire sdaOe,
   // Configuration and strobes.
   input wire [7:0] powerAdcCtrl,
   input wire [7:0] integrationTime,
   input wire [15:0] lowThresh,
   input wire irqClearPulse_ff,
   input wire manualStopPulse_ff,
   input wire manualStartPulse_ff
);
   reg sclPrev_ff;
   reg [7:0] sinceFall_ff;
   wire [2:0] pulses = {irqClearPulse_ff, manualStopPulse_ff, manualStartPulse_ff};

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   // Cycles since the serial clock pin fell; saturates so a long idle never wraps.
   always @(posedge clk)
   begin
      sclPrev_ff <= sclIn;
      if (!rstn)
         sinceFall_ff <= 8'hFF;
      else if (sclPrev_ff && !sclIn)
         sinceFall_ff <= 8'h00;
      else if (sinceFall_ff != 8'hFF)
         sinceFall_ff <= sinceFall_ff + 8'h01;
   end

   sequence s_stop;
      sclIn && $past(sclIn) && $rose(sdaIn);
   endsequence
   sequence s_byte_end;
      sinceFall_ff > 8'h00 && sinceFall_ff < 8'h0A;
   endsequence

   a_drive_value_zero:
      assert property (sdaOut == 1'b0)
      else $error("data line drive value not zero");
   a_reset_state:
      assert property ($rose(rstn) |-> !sdaOe && pulses == 3'h0 && powerAdcCtrl == 8'h00
         && integrationTime == 8'h00 && lowThresh == 16'h0000)
      else $error("outputs not cleared by reset");
   a_strobe_single:
      assert property (pulses != 3'h0 |=> pulses == 3'h0)
      else $error("strobe longer than one cycle");
   a_strobe_onehot:
      assert property ($onehot0(pulses))
      else $error("two strobes at once");
   a_manual_gated:
      assert property ((manualStopPulse_ff || manualStartPulse_ff) |-> integrationTime == 8'h00)
      else $error("manual strobe with nonzero timing");
   a_strobe_after_byte:
      assert property (pulses != 3'h0 |-> s_byte_end)
      else $error("strobe not tied to a received byte");
   a_cfg_after_byte:
      assert property ($changed({powerAdcCtrl, integrationTime, lowThresh}) |-> s_byte_end)
      else $error("configuration changed outside a received byte");
   a_stop_release:
      assert property (s_stop |=> !sdaOe [*8])
      else $error("data line driven after stop");
   a_drive_after_fall:
      assert property ($rose(sdaOe) |-> sinceFall_ff > 8'h01 && sinceFall_ff < 8'h08)
      else $error("data line drive not timed to clock fall");
endmodule

bind lsc_cmd_regs lsc_cmd_regs_props chk (.clk(clk), .rstn(rstn), .sclIn(sclIn),
   .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .powerAdcCtrl(powerAdcCtrl),
   .integrationTime(integrationTime), .lowThresh(lowThresh),
   .irqClearPulse_ff(irqClearPulse_ff), .manualStopPulse_ff(manualStopPulse_ff),
   .manualStartPulse_ff(manualStartPulse_ff));

// ### tb/lsc_host_model.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Two-wire bus master model
// ----------------------------------------------------------------------
module lsc_host_model (
   // Time base.
   input wire clk,
   // Link; sdaLow pulls the data line down, released it floats high.
   input wire sda,
   output reg scl,
   output reg sdaLow,
   // One strobe for each byte read back.
   output reg rxStrobe,
   output reg [7:0] rxData
);
   // Idle bus at time zero.
   initial
   begin
      scl = 1'b1;
      sdaLow = 1'b0;
      rxStrobe = 1'b0;
      rxData = 8'h00;
   end

   // All line changes happen on falling system clock edges, off the sampling edge.
   task tick(input integer n);
      repeat (n) @(negedge clk);
   endtask

   // Waits four cycles first so a slave acknowledge has been released before the rise.
   task start;
   begin
      sdaLow = 1'b0;
      tick(4);
      scl = 1'b1;
      tick(3);
      sdaLow = 1'b1;
      tick(5);
      scl = 1'b0;
      tick(2);
   end
   endtask

   // Ends every frame; the slave keeps taking bytes until here, and gives bytes until a not-acknowledge.
   task stop;
   begin
      sdaLow = 1'b1;
      tick(3);
      scl = 1'b1;
      tick(3);
      sdaLow = 1'b0;
      tick(5);
   end
   endtask

   // One bit of ten cycles, 80 ns; the line is sampled mid-way through the high phase.
   task clkBit(input b, output s);
   begin
      sdaLow = !b;
      tick(3);
      scl = 1'b1;
      tick(3);
      s = sda;
      tick(2);
      scl = 1'b0;
      tick(2);
   end
   endtask

   task wbyte(input [7:0] b, output nack);
      integer i;
      reg s;
   begin
      for (i = 7; i >= 0; i = i - 1)
         clkBit(b[i], s);
      clkBit(1'b1, nack);
   end
   endtask

   // A not-acknowledged last byte tells the slave to stop sending.
   task rbyte(input last);
      integer i;
      reg [7:0] d;
      reg s;
   begin
      for (i = 7; i >= 0; i = i - 1)
         clkBit(1'b1, d[i]);
      clkBit(last, s);
      rxData = d;
      rxStrobe = 1'b1;
      tick(1);
      rxStrobe = 1'b0;
   end
   endtask
endmodule

// ### tb/tb.sv
`timescale 1ns/10ps

module tb;
   reg clk, rstn, irqAct, adcVal, ack;
   reg [15:0] ch0, ch1, man;
   reg [7:0] expQ[$];
   reg [7:0] w[0:7];
   wire sdaOut, sdaOe, scl, sdaLow, rxStrobe, irqP, stopP, startP;
   wire [7:0] rxData, pwr, itime, irqc, gain;
   wire [15:0] lowT, highT;
   wire sda = !(sdaLow || (sdaOe && !sdaOut));
   integer n_fail, cmp_count, k, j, nIrq, nStop, nStart;

   lsc_cmd_regs #(.SMBUS_MODE(1)) dut (.clk(clk), .rstn(rstn), .sclIn(scl), .sdaIn(sda),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .ch0Result(ch0), .ch1Result(ch1), .manualPeriod(man),
      .adcIrqActive(irqAct), .adcValid(adcVal), .powerAdcCtrl(pwr), .integrationTime(itime),
      .irqCtrl(irqc), .lowThresh(lowT), .highThresh(highT), .gainCtrl(gain),
      .irqClearPulse_ff(irqP), .manualStopPulse_ff(stopP), .manualStartPulse_ff(startP));
   lsc_host_model host (.clk(clk), .sda(sda), .scl(scl), .sdaLow(sdaLow),
      .rxStrobe(rxStrobe), .rxData(rxData));

   // 125 MHz system clock.
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task check(input [15:0] seen, input [15:0] exp);
   begin
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
         n_fail = n_fail + 1;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   end
   endtask

   // Each byte read back is matched against the oldest expectation.
   always @(posedge clk)
   begin
      if (rxStrobe && expQ.size() == 0)
         check(16'h0100, {8'h00, rxData});
      else if (rxStrobe)
         check({8'h00, rxData}, {8'h00, expQ.pop_front()});
   end

   // Strobe counters; only single-cycle strobes give one count each.
   always @(posedge clk)
   begin
      nIrq <= nIrq + irqP;
      nStop <= nStop + stopP;
      nStart <= nStart + startP;
   end

   // The pointer is always written first, then the data bytes follow.
   task wr(input [7:0] cmd, input integer n);
   begin
      host.start;
      host.wbyte(8'h72, ack);
      check({15'h0000, ack}, 16'h0000);
      host.wbyte(cmd, ack);
      for (k = 0; k < n; k = k + 1)
         host.wbyte(w[k], ack);
      host.stop;
   end
   endtask

   // Combined format when cmd is a command byte, plain receive otherwise.
   task rd(input [7:0] cmd, input integer n);
   begin
      host.start;
      if (cmd[7])
      begin
         host.wbyte(8'h72, ack);
         host.wbyte(cmd, ack);
         host.start;
      end
      host.wbyte(8'h73, ack);
      for (j = 0; j < n; j = j + 1)
         host.rbyte(j == n - 1);
      host.stop;
   end
   endtask

   task close_out;
   begin
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   end
   endtask

   // Cuts a hang short.
   initial
   begin
      repeat (100000) @(posedge clk);
      n_fail = n_fail + 1;
      close_out;
   end

   initial
   begin
      {rstn, irqAct, adcVal, n_fail, cmp_count, nIrq, nStop, nStart} = 0;
      irqAct = 1'b1;
      k = $urandom(32'hD28A0060);
      {ch0, ch1} = $urandom;
      man = 16'($urandom);
      repeat (16) @(negedge clk);
      rstn = 1'b1;
      host.tick(4);
      expQ.push_back(8'h20);
      rd(8'h00, 1);
      $display("test reset pointer done");
      for (k = 0; k < 8; k = k + 1)
         w[k] = 8'($urandom) & 8'h7F;
      w[0] = w[0] & 8'hCF;
      wr(8'hA0, 8);
      check({pwr, itime}, {w[0], w[1]});
      check({irqc, gain}, {w[2], w[7]});
      check(lowT, {w[4], w[3]});
      check(highT, {w[6], w[5]});
      expQ.push_back(w[0] | 8'h20);
      for (k = 1; k < 8; k = k + 1)
         expQ.push_back(w[k]);
      rd(8'hA0, 8);
      w[0] = 8'h02;
      wr(8'hC5, 3);
      check(highT, {w[2], w[1]});
      $display("test config registers done");
      expQ = {8'h04, ch0[7:0], ch0[15:8], ch1[7:0], ch1[15:8], man[7:0], man[15:8]};
      rd(8'hD3, 7);
      $display("test block read done");
      {ch0, ch1} = $urandom;
      w[0] = ~ch0[7:0] & 8'h7F;
      wr(8'h94, 1);
      expQ = {ch0[7:0], ch0[7:0], 8'h5A, 8'h00, w[1]};
      rd(8'h94, 2);
      rd(8'h92, 1);
      rd(8'h88, 1);
      rd(8'h81, 1);
      $display("test read-only and byte type done");
      w[0] = 8'h00;
      wr(8'h81, 1);
      wr(8'hE1, 0);
      wr(8'hE3, 0);
      wr(8'hE2, 0);
      w[0] = 8'h11;
      wr(8'h81, 1);
      wr(8'hE3, 0);
      wr(8'hE2, 0);
      check(nIrq, 1);
      check({nStart[7:0], nStop[7:0]}, 16'h0101);
      $display("test special functions done");
      host.start;
      host.wbyte(8'h50, ack);
      host.stop;
      check({15'h0000, ack}, 16'h0001);
      $display("test foreign address done");
      rstn = 1'b0;
      host.tick(4);
      rstn = 1'b1;
      {irqAct, adcVal} = 2'h1;
      host.tick(4);
      check(lowT, 16'h0000);
      check({8'h00, itime}, 16'h0000);
      expQ.push_back(8'h10);
      rd(8'h00, 1);
      host.tick(20);
      check(expQ.size(), 0);
      $display("test second reset done");
      close_out;
   end
endmodule
